// ---- design/tdm_parallel_access.sv ----
// tdm parallel access: serial framing, dynamic interrupt paths, ram port, bus controller
// assumes i_clk far above the serial bit clock; pins arrive asynchronously
//
// Function
// - match/mask bit pair selects ignore, rise, fall or any change per bit.
// - a change compares this frame's bit with the previous frame's bit.
// - vector fetch acknowledge drives the vector with the interrupting path bit set.
// - image holds the causing channel byte until the interrupt is cleared.
// - flags mark causing positions; a flag read returns, clears them and the interrupt.
// - clear command empties image, flags and the vector path bits.
// - each path has its own type select and its own request enable.
// - strap pin low resets the previous byte, image, flag and pending registers of both paths to zero.
// - in ram mode only the three buffers work; interrupt logic is idle.
// - channel-count select low gives 24 channels, high gives 32.
// - ram mode host port behaves as a static memory with select, enable, direction.
// - low five address bits pick channel; reads hit receive, writes pick a or b.
// - serial converters touch buffers only at the end of each channel.
// - collisions: reads at the current channel, writes at the next channel.
// - collision raises busy; host holds its access until busy drops.
// - bus controller drives address, output and write enables; buffer b unused.
// - during channel n, read address n+1 first, then write address n-1.
// - bus controller outputs change only with the serial bit clock.
// - channel start strobe covers the first half of every channel.
// - second half select covers the last half of every channel.
// - vector holds six written upper bits; bit 1 path 2, bit 0 path 1.
`timescale 1ns/10ps
module tdm_parallel_access #(
  parameter int DATA_W = 8
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // serial side pins
  input wire logic i_serial_bit_clock,
  input wire logic i_frame_n,
  input wire logic i_serial_in,
  output logic o_serial_out_a,
  output logic o_serial_out_b,
  // mode straps
  input wire logic i_mode_strap_reset,
  input wire logic i_mode_select,
  input wire logic i_channel_count_sel,
  // interrupt control, same clock domain
  input wire logic i_path1_type_select,
  input wire logic i_path2_type_select,
  input wire logic i_path1_enable,
  input wire logic i_path2_enable,
  input wire logic i_interrupt_clear_cmd,
  input wire logic i_path1_flag_read,
  input wire logic i_path2_flag_read,
  input wire logic [tdm_access_pkg::CH_W-1:0] i_path1_chan,
  input wire logic [tdm_access_pkg::CH_W-1:0] i_path2_chan,
  input wire logic [DATA_W-1:0] i_path1_match,
  input wire logic [DATA_W-1:0] i_path2_match,
  input wire logic [DATA_W-1:0] i_path1_mask,
  input wire logic [DATA_W-1:0] i_path2_mask,
  input wire logic [5:0] i_vector_upper,
  input wire logic i_vector_fetch_ack_n,
  // interrupt status
  output logic o_irq_n,
  output logic o_vector_valid,
  output logic [DATA_W-1:0] o_vector_data,
  output logic [DATA_W-1:0] o_path1_flag,
  output logic [DATA_W-1:0] o_path2_flag,
  output logic [DATA_W-1:0] o_path1_image,
  output logic [DATA_W-1:0] o_path2_image,
  // ram port pins
  input wire logic i_cs_n,
  input wire logic i_oe_n,
  input wire logic i_rw,
  input wire logic [tdm_access_pkg::ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  output logic [DATA_W-1:0] o_rdata,
  output logic o_busy,
  // bus controller pins
  input wire logic [DATA_W-1:0] i_ext_data,
  output logic [DATA_W-1:0] o_ext_data,
  output logic o_ext_data_oe_n,
  output logic [tdm_access_pkg::CH_W-1:0] o_ext_addr,
  output logic o_ext_oe_n,
  output logic o_ext_we_n,
  output logic o_channel_start_strobe,
  output logic o_second_half_select
);
  import tdm_access_pkg::*;

  if (DATA_W != 8) begin : g_width_check
    $error("DATA_W must be 8");
  end

  function automatic logic [CH_W-1:0] next_ch(input logic [CH_W-1:0] c, input logic [CH_W-1:0] m);
    next_ch = (c == m) ? '0 : c + 1'b1;
  endfunction

  function automatic logic [CH_W-1:0] prev_ch(input logic [CH_W-1:0] c, input logic [CH_W-1:0] m);
    prev_ch = (c == '0) ? m : c - 1'b1;
  endfunction

  // per-bit transition detect: 01 rise, 10 fall, 11 any change, 00 ignored
  function automatic logic [DATA_W-1:0] dyn_hit(input logic [DATA_W-1:0] p, input logic [DATA_W-1:0] c,
                                                input logic [DATA_W-1:0] mt, input logic [DATA_W-1:0] mk);
    dyn_hit = (mk & ~mt & ~p & c) | (mt & ~mk & p & ~c) | (mt & mk & (p ^ c));
  endfunction

  // ****************
  // pin synchronisers
  // ****************
  logic [PIN_W-1:0] pin_meta_reg, pin_sync_reg;
  logic bclk_s, frame_n_s, ser_in_s, strap_s, msel_s, cnt32_s, ack_n_s, cs_n_s, oe_n_s, rw_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] wdata_s, ext_s;
  assign {bclk_s, frame_n_s, ser_in_s, strap_s, msel_s, cnt32_s, ack_n_s, cs_n_s, oe_n_s, rw_s,
          addr_s, wdata_s, ext_s} = pin_sync_reg;

  // every pin bundle crosses in two flops before anything reads it
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pin_meta_reg <= PIN_IDLE;
      pin_sync_reg <= PIN_IDLE;
    end else begin
      pin_meta_reg <= {i_serial_bit_clock, i_frame_n, i_serial_in, i_mode_strap_reset, i_mode_select,
                       i_channel_count_sel, i_vector_fetch_ack_n, i_cs_n, i_oe_n, i_rw, i_addr, i_wdata, i_ext_data};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ****************
  // channel timing
  // ****************
  logic bclk_d_reg, fall_evt, byte_done;
  logic [3:0] cnt_reg, cnt_next;
  logic [CH_W-1:0] ch_reg, ch_next, ch_max, nch, pch;
  mode_e mode;

  // bit-clock falling edges advance the channel; a low frame pulse realigns to channel 0
  always_comb begin
    ch_max = cnt32_s ? CH_MAX_32 : CH_MAX_24;
    fall_evt = bclk_d_reg & ~bclk_s;
    byte_done = fall_evt && (cnt_reg == CNT_LAST);
    cnt_next = cnt_reg;
    ch_next = ch_reg;
    if (fall_evt && !frame_n_s) begin
      cnt_next = '0;
      ch_next = '0;
    end else if (fall_evt) begin
      cnt_next = cnt_reg + 4'h1;
      if (byte_done) begin
        ch_next = next_ch(ch_reg, ch_max);
      end
    end
    nch = next_ch(ch_reg, ch_max);
    pch = prev_ch(ch_reg, ch_max);
    if (strap_s) begin
      mode = MODE_INTR;
    end else if (msel_s) begin
      mode = MODE_RAM;
    end else begin
      mode = MODE_BUSCTRL;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      bclk_d_reg <= 1'b0;
      cnt_reg <= '0;
      ch_reg <= '0;
    end else begin
      bclk_d_reg <= bclk_s;
      cnt_reg <= cnt_next;
      ch_reg <= ch_next;
    end
  end

  // ****************
  // buffers, converters, ram port, bus controller
  // ****************
  logic [DATA_W-1:0] receive_buffer_reg [CH_DEPTH], rx_next [CH_DEPTH];
  logic [DATA_W-1:0] transmit_buffer_a_reg [CH_DEPTH], txa_next [CH_DEPTH];
  logic [DATA_W-1:0] transmit_buffer_b_reg [CH_DEPTH], txb_next [CH_DEPTH];
  logic [DATA_W-1:0] rx_sh_reg, rx_sh_next, rx_byte, txa_cur_reg, txa_cur_next, txb_cur_reg, txb_cur_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next, ext_data_reg, ext_data_next;
  logic [CH_W-1:0] host_ch, ext_addr_reg, ext_addr_next;
  logic out_a_reg, out_a_next, out_b_reg, out_b_next, busy_reg, busy_next;
  logic host_rd, host_wr, coll, drive;
  logic ext_oe_n_reg, ext_oe_n_next, ext_we_n_reg, ext_we_n_next, channel_start_strobe_reg, channel_start_strobe_next, dcs_reg, dcs_next;

  always_comb begin
    rx_byte = {rx_sh_reg[DATA_W-2:0], ser_in_s};
    rx_sh_next = (fall_evt && cnt_reg[0]) ? rx_byte : rx_sh_reg;
    rx_next = receive_buffer_reg;
    txa_next = transmit_buffer_a_reg;
    txb_next = transmit_buffer_b_reg;
    txa_cur_next = txa_cur_reg;
    txb_cur_next = txb_cur_reg;
    // converters touch memory in one slot only, which keeps contention rare
    if (byte_done) begin
      rx_next[ch_reg] = rx_byte;
      txa_cur_next = transmit_buffer_a_reg[nch];
      txb_cur_next = transmit_buffer_b_reg[nch];
    end
    host_ch = addr_s[CH_W-1:0];
    host_rd = (mode != MODE_BUSCTRL) && !cs_n_s && rw_s && !oe_n_s;
    host_wr = (mode != MODE_BUSCTRL) && !cs_n_s && !rw_s;
    coll = (cnt_reg == CNT_LAST) && ((host_rd && host_ch == ch_reg) || (host_wr && host_ch == nch));
    busy_next = coll;
    rdata_next = rdata_reg;
    if (host_rd && !coll) begin
      rdata_next = receive_buffer_reg[host_ch];
    end
    if (host_wr && !coll && addr_s[ADDR_W-1]) begin
      txb_next[host_ch] = wdata_s;
    end else if (host_wr && !coll) begin
      txa_next[host_ch] = wdata_s;
    end
    // select gates the bus drivers; each half runs a read phase, then a write phase, from the low count bits
    drive = (mode == MODE_BUSCTRL) && !cs_n_s;
    if (fall_evt && drive && cnt_reg[2:0] == PHASE_RD_LAST) begin
      txa_next[nch] = ext_s;
    end
    ext_addr_next = ext_addr_reg;
    ext_oe_n_next = ext_oe_n_reg;
    ext_we_n_next = ext_we_n_reg;
    ext_data_next = ext_data_reg;
    channel_start_strobe_next = channel_start_strobe_reg;
    dcs_next = dcs_reg;
    out_a_next = out_a_reg;
    out_b_next = out_b_reg;
    if (fall_evt) begin
      ext_addr_next = (cnt_next[2:0] <= PHASE_RD_LAST) ? next_ch(ch_next, ch_max) : prev_ch(ch_next, ch_max);
      ext_oe_n_next = !(drive && cnt_next[2:0] <= PHASE_RD_LAST);
      ext_we_n_next = !(drive && cnt_next[2:0] > PHASE_RD_LAST);
      ext_data_next = receive_buffer_reg[prev_ch(ch_next, ch_max)];
      channel_start_strobe_next = (mode == MODE_BUSCTRL) && (cnt_next < HALF_CNT);
      dcs_next = (mode == MODE_BUSCTRL) && (cnt_next >= HALF_CNT);
      out_a_next = txa_cur_next[~cnt_next[3:1]];
      out_b_next = (mode == MODE_BUSCTRL) ? 1'b1 : txb_cur_next[~cnt_next[3:1]];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      receive_buffer_reg <= '{default: BYTE_ZERO};
      transmit_buffer_a_reg <= '{default: BYTE_ZERO};
      transmit_buffer_b_reg <= '{default: BYTE_ZERO};
      rx_sh_reg <= '0;
      txa_cur_reg <= '0;
      txb_cur_reg <= '0;
      rdata_reg <= '0;
      busy_reg <= 1'b0;
      ext_addr_reg <= '0;
      ext_oe_n_reg <= 1'b1;
      ext_we_n_reg <= 1'b1;
      ext_data_reg <= '0;
      channel_start_strobe_reg <= 1'b0;
      dcs_reg <= 1'b0;
      out_a_reg <= 1'b1;
      out_b_reg <= 1'b1;
    end else begin
      receive_buffer_reg <= rx_next;
      transmit_buffer_a_reg <= txa_next;
      transmit_buffer_b_reg <= txb_next;
      rx_sh_reg <= rx_sh_next;
      txa_cur_reg <= txa_cur_next;
      txb_cur_reg <= txb_cur_next;
      rdata_reg <= rdata_next;
      busy_reg <= busy_next;
      ext_addr_reg <= ext_addr_next;
      ext_oe_n_reg <= ext_oe_n_next;
      ext_we_n_reg <= ext_we_n_next;
      ext_data_reg <= ext_data_next;
      channel_start_strobe_reg <= channel_start_strobe_next;
      dcs_reg <= dcs_next;
      out_a_reg <= out_a_next;
      out_b_reg <= out_b_next;
    end
  end

  // ****************
  // dynamic interrupt paths
  // ****************
  logic [1:0] type_sel, en_vec, flag_rd, sel, set, clr, pend_reg, pend_next;
  logic [DATA_W-1:0] match [2], mask [2], hit [2];
  logic [DATA_W-1:0] prev_reg [2], prev_next [2], image_reg [2], image_next [2], flag_reg [2], flag_next [2];
  logic [CH_W-1:0] path_ch [2];
  logic [DATA_W-1:0] vec_reg, vec_next;
  logic irq_n_reg, irq_n_next, vec_valid_reg, vec_valid_next;
  assign type_sel = {i_path2_type_select, i_path1_type_select};
  assign en_vec = {i_path2_enable, i_path1_enable};
  assign flag_rd = {i_path2_flag_read, i_path1_flag_read};
  assign match = '{i_path1_match, i_path2_match};
  assign mask = '{i_path1_mask, i_path2_mask};
  assign path_ch = '{i_path1_chan, i_path2_chan};

  // a new event beats a clear in the same cycle, so no transition is lost
  always_comb begin
    prev_next = prev_reg;
    image_next = image_reg;
    flag_next = flag_reg;
    pend_next = pend_reg;
    for (int p = 0; p < 2; p++) begin
      hit[p] = dyn_hit(prev_reg[p], rx_byte, match[p], mask[p]);
      sel[p] = byte_done && (ch_reg == path_ch[p]);
      set[p] = sel[p] && type_sel[p] && (hit[p] != BYTE_ZERO);
      clr[p] = i_interrupt_clear_cmd || flag_rd[p];
      if (sel[p]) begin
        prev_next[p] = rx_byte;
      end
      if (sel[p] && !pend_reg[p]) begin
        image_next[p] = rx_byte;
      end
      if (clr[p]) begin
        flag_next[p] = BYTE_ZERO;
        pend_next[p] = 1'b0;
      end
      if (i_interrupt_clear_cmd) begin
        image_next[p] = BYTE_ZERO;
      end
      if (set[p]) begin
        flag_next[p] = flag_next[p] | hit[p];
        pend_next[p] = 1'b1;
        if (!pend_reg[p] || clr[p]) begin
          image_next[p] = rx_byte;
        end
      end
      if (mode != MODE_INTR) begin
        prev_next[p] = BYTE_ZERO;
        image_next[p] = BYTE_ZERO;
        flag_next[p] = BYTE_ZERO;
        pend_next[p] = 1'b0;
      end
    end
    irq_n_next = ~|(pend_next & en_vec);
    vec_valid_next = !ack_n_s && (pend_next != 2'b00);
    vec_next = vec_valid_next ? {i_vector_upper, pend_next} : BYTE_ZERO;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      prev_reg <= '{default: BYTE_ZERO};
      image_reg <= '{default: BYTE_ZERO};
      flag_reg <= '{default: BYTE_ZERO};
      pend_reg <= 2'b00;
      irq_n_reg <= 1'b1;
      vec_valid_reg <= 1'b0;
      vec_reg <= '0;
    end else begin
      prev_reg <= prev_next;
      image_reg <= image_next;
      flag_reg <= flag_next;
      pend_reg <= pend_next;
      irq_n_reg <= irq_n_next;
      vec_valid_reg <= vec_valid_next;
      vec_reg <= vec_next;
    end
  end

  assign o_serial_out_a = out_a_reg;
  assign o_serial_out_b = out_b_reg;
  assign o_irq_n = irq_n_reg;
  assign o_vector_valid = vec_valid_reg;
  assign o_vector_data = vec_reg;
  assign o_path1_flag = flag_reg[0];
  assign o_path2_flag = flag_reg[1];
  assign o_path1_image = image_reg[0];
  assign o_path2_image = image_reg[1];
  assign o_rdata = rdata_reg;
  assign o_busy = busy_reg;
  assign o_ext_data = ext_data_reg;
  assign o_ext_data_oe_n = ext_we_n_reg;
  assign o_ext_addr = ext_addr_reg;
  assign o_ext_oe_n = ext_oe_n_reg;
  assign o_ext_we_n = ext_we_n_reg;
  assign o_channel_start_strobe = channel_start_strobe_reg;
  assign o_second_half_select = dcs_reg;

  // ****************
  // checks
  // ****************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence s_pick1; sel[0] && type_sel[0] && mode == MODE_INTR; endsequence
  sequence s_quiet1; !i_interrupt_clear_cmd && !flag_rd[0]; endsequence

  a_rise_detect: assert property (
    (s_pick1 ##0 ((mask[0] & ~match[0] & ~prev_reg[0] & rx_byte) != BYTE_ZERO)) |=> pend_reg[0] && flag_reg[0] != 0)
    else $error("rise not flagged");
  a_prev_frame: assert property (sel[0] && mode == MODE_INTR |=> prev_reg[0] == $past(rx_byte))
    else $error("previous frame byte lost");
  a_vector_bits: assert property (
    o_vector_valid |-> o_vector_data == {$past(i_vector_upper), pend_reg} && !$past(ack_n_s))
    else $error("vector wrong");
  a_image_frozen: assert property (
    (pend_reg[0] ##0 s_quiet1 ##0 mode == MODE_INTR) |=> $stable(image_reg[0]))
    else $error("image moved while pending");
  a_flag_read: assert property (flag_rd[0] && !set[0] |=> flag_reg[0] == 0 && !pend_reg[0])
    else $error("flag read did not clear");
  a_clear_cmd: assert property (
    i_interrupt_clear_cmd && set == 2'b00 |=> image_reg[0] == 0 && image_reg[1] == 0 && pend_reg == 0)
    else $error("clear command incomplete");
  a_irq_level: assert property (1'b1 |=> o_irq_n == !(|(pend_reg & $past(en_vec))))
    else $error("request level wrong");
  a_strap_clear: assert property (mode != MODE_INTR |=> pend_reg == 0 && flag_reg[0] == 0)
    else $error("interrupt state alive outside mode");
  a_busy_window: assert property (o_busy |-> $past(cnt_reg) == CNT_LAST && $past(coll))
    else $error("busy outside window");
  a_read_addr: assert property ($fell(o_ext_oe_n) |-> o_ext_addr == next_ch(ch_reg, ch_max))
    else $error("read address not n+1");
  a_bus_sync: assert property ($changed(o_ext_addr) || $changed(o_ext_we_n) |-> $past(fall_evt))
    else $error("bus moved off bit clock");
  a_half_strobes: assert property (o_channel_start_strobe |-> cnt_reg < HALF_CNT && !o_second_half_select)
    else $error("start strobe outside first half");
endmodule

// ---- shared/tdm_access_pkg.sv ----
// shared constants of the tdm parallel access block
// assumes one fast system clock; serial, strap, host, bus and acknowledge pins enter through a two-stage synchroniser
package tdm_access_pkg;
  // ****************
  // channel timing
  // ****************
  localparam int CH_W = 5;
  localparam int ADDR_W = 6;
  localparam int CH_DEPTH = 32;
  localparam int PIN_W = 32;
  localparam logic [3:0] CNT_LAST = 4'hF;        // last bit-clock cycle of a channel
  localparam logic [3:0] HALF_CNT = 4'h8;        // first bit-clock cycle of the second half
  localparam logic [2:0] PHASE_RD_LAST = 3'h3;   // read phase ends here, write phase follows
  localparam logic [4:0] CH_MAX_32 = 5'h1F;
  localparam logic [4:0] CH_MAX_24 = 5'h17;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // idle level of the synchronised pin bundle: strobes and active-low pins high
  localparam logic [31:0] PIN_IDLE = 32'h53C0_0000;
  // ****************
  // operating modes
  // ****************
  typedef enum logic [1:0] {MODE_INTR, MODE_RAM, MODE_BUSCTRL} mode_e;
endpackage

// ---- testbench/tb.sv ----
// self-checking bench of the tdm parallel access block with host model and serial stream
// assumes the package constants; the bench makes the serial bit clock at 1/12 of i_clk
`timescale 1ns/10ps
module tb;
  import tdm_access_pkg::*;
  // ****************
  // signals
  // ****************
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic bclk = 1'b0;
  logic frame_n = 1'b1;
  logic sin = 1'b1;
  logic strap = 1'b1;
  logic msel = 1'b0;
  logic csel = 1'b1;
  logic [7:0] ctl = 8'h87;  // ack_n, rd2, rd1, clear, en2, en1, type2, type1
  logic [7:0] mt2, mk2, xin = 8'h00;
  logic [5:0] vup;
  logic irq_n, vvalid, busy, xdoe, xoe, xwe, channel_start_strobe, second_half_select, soa, sob, cs_n, oe_n, rw;
  logic [7:0] vdata, f1, f2, im1, im2, rdata, xdata, wdata;
  logic [5:0] addr;
  logic [4:0] xaddr;
  logic [2:0] div = 3'd0;
  logic [3:0] cnt = 4'hF;
  logic [4:0] ch = 5'h1F;
  logic [4:0] nch_m1 = 5'h1F;
  logic [7:0] dat [32];
  logic [7:0] got_a [32];
  logic [7:0] got_b [32];
  logic [7:0] lat [32];  // byte the bus controller should latch for each channel
  logic [7:0] xr;
  logic [7:0] sh_a, sh_b;
  logic m3 = 1'b0;
  logic [31:0] seed = 32'h0000_ed53;
  int nfr = 0;
  int mismatches = 0;
  int n_compared = 0;
  always #2 i_clk = ~i_clk;
  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // events per bit: mask marks rises, match marks falls, both mark any change
  function automatic logic [7:0] hit(input logic [7:0] p, c, mt, mk);
    return (mk & ~p & c) | (mt & p & ~c);
  endfunction
  function automatic logic [4:0] nxt(input logic [4:0] c);
    return (c == nch_m1) ? 5'h00 : c + 5'h01;
  endfunction
  function automatic logic [4:0] prv(input logic [4:0] c);
    return (c == 5'h00) ? nch_m1 : c - 5'h01;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // bounded waits: a limit that runs out ends the run as a failure
  task automatic frames(input int n);
    int t;
    int k;
    t = nfr + n;
    for (k = 0; k < n * 7000 && nfr < t; k++) @(posedge i_clk);
    if (nfr < t) begin
      mismatches++;
      $display("Error at %0t: frame wait timed out", $time);
      conclude();
    end
  endtask
  task automatic at_cnt(input logic [3:0] k);
    int t;
    for (t = 0; t < 400 && cnt !== k; t++) @(posedge i_clk);
    if (cnt !== k) begin
      mismatches++;
      $display("Error at %0t: bit count wait timed out", $time);
      conclude();
    end
  endtask
  task automatic pulse(input int b);
    @(posedge i_clk);
    ctl[b] <= 1'b1;
    @(posedge i_clk);
    ctl[b] <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask
  // ****************
  // serial side and bus-controller monitor
  // ****************
  // falls advance the bench position; rises drive data mid bit, where outputs are settled
  always @(posedge i_clk) begin
    div <= (div == 3'd5) ? 3'd0 : div + 3'd1;
    if (div == 3'd5) begin
      bclk <= ~bclk;
      if (bclk) begin
        cnt <= frame_n ? cnt + 4'h1 : 4'h0;
        if (!frame_n) nfr <= nfr + 1;
        if (!frame_n) ch <= 5'h00;
        else if (cnt == 4'hF) ch <= nxt(ch);
      end else begin
        frame_n <= !(cnt == 4'hF && ch == nch_m1);
        xr = 8'(rnd());
        xin <= xr;
        // the fall ending bit cycle 11 latches this value into transmit buffer a of the next channel
        if (cnt == 4'hB) lat[nxt(ch)] <= xr;
        if (!cnt[0]) begin
          sin <= dat[ch][3'd7 - cnt[3:1]];
          sh_a <= {sh_a[6:0], soa};
          sh_b <= {sh_b[6:0], sob};
        end
        if (cnt == 4'hE) begin
          got_a[ch] <= {sh_a[6:0], soa};
          got_b[ch] <= {sh_b[6:0], sob};
        end
        if (m3) begin
          chk({channel_start_strobe, second_half_select}, {cnt < 4'h8, cnt >= 4'h8});
          chk(xaddr, cnt[2] ? prv(ch) : nxt(ch));
          chk({xoe, xwe, xdoe}, cnt[2] ? 3'b100 : 3'b011);
          if (cnt[2]) chk(xdata, dat[prv(ch)]);
          if (cnt == 4'hE) chk({sh_a[6:0], soa, sh_b[6:0], sob}, {lat[ch], 8'hFF});
        end
      end
    end
  end
  // ****************
  // instances
  // ****************
  tdm_host_model tdm_host_model_i (.i_clk(i_clk), .i_busy(busy), .i_rdata(rdata), .o_cs_n(cs_n),
    .o_oe_n(oe_n), .o_rw(rw), .o_addr(addr), .o_wdata(wdata));
  tdm_parallel_access tdm_parallel_access_i (.i_clk(i_clk), .i_srst(i_srst), .i_serial_bit_clock(bclk),
    .i_frame_n(frame_n), .i_serial_in(sin), .o_serial_out_a(soa), .o_serial_out_b(sob),
    .i_mode_strap_reset(strap), .i_mode_select(msel), .i_channel_count_sel(csel),
    .i_path1_type_select(ctl[0]), .i_path2_type_select(ctl[1]), .i_path1_enable(ctl[2]),
    .i_path2_enable(ctl[3]), .i_interrupt_clear_cmd(ctl[4]), .i_path1_flag_read(ctl[5]),
    .i_path2_flag_read(ctl[6]), .i_path1_chan(5'h04), .i_path2_chan(5'h09), .i_path1_match(8'hF0),
    .i_path2_match(mt2), .i_path1_mask(8'hCC), .i_path2_mask(mk2), .i_vector_upper(vup),
    .i_vector_fetch_ack_n(ctl[7]), .o_irq_n(irq_n), .o_vector_valid(vvalid), .o_vector_data(vdata),
    .o_path1_flag(f1), .o_path2_flag(f2), .o_path1_image(im1), .o_path2_image(im2), .i_cs_n(cs_n),
    .i_oe_n(oe_n), .i_rw(rw), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_busy(busy),
    .i_ext_data(xin), .o_ext_data(xdata), .o_ext_data_oe_n(xdoe), .o_ext_addr(xaddr), .o_ext_oe_n(xoe),
    .o_ext_we_n(xwe), .o_channel_start_strobe(channel_start_strobe), .o_second_half_select(second_half_select));
  // main sequence: interrupt paths, strap wipe, ram port with collisions, bus controller
  initial begin
    int i;
    int bz;
    logic [7:0] p1, p2, e1, e2, i1, i2, q, wa, wb;
    logic [4:0] c, cw;
    logic pn1, pn2;
    for (i = 0; i < 32; i++) dat[i] = 8'(rnd());
    mt2 = 8'(rnd()) | 8'h01;
    mk2 = 8'(rnd()) | 8'h01;
    vup = 6'(rnd());
    repeat (4) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    chk({irq_n, f1, im1, busy}, {1'b1, 16'h0000, 1'b0});
    frames(2);
    pulse(4);
    chk({f1, f2, im1, im2, irq_n}, {32'h0000_0000, 1'b1});
    {e1, e2, i1, i2, pn1, pn2} = 34'h0_0000_0000;
    frames(1);
    for (i = 0; i < 2; i++) begin
      p1 = dat[4];
      p2 = dat[9];
      dat[4] = (i == 0) ? p1 ^ 8'h80 : 8'(rnd());
      dat[9] = (i == 0) ? p2 ^ 8'h01 : 8'(rnd());
      if (!pn1 && hit(p1, dat[4], 8'hF0, 8'hCC) != 8'h00) i1 = dat[4];
      if (!pn2 && hit(p2, dat[9], mt2, mk2) != 8'h00) i2 = dat[9];
      e1 = e1 | hit(p1, dat[4], 8'hF0, 8'hCC);
      e2 = e2 | hit(p2, dat[9], mt2, mk2);
      pn1 = pn1 | (e1 != 8'h00);
      pn2 = pn2 | (e2 != 8'h00);
      frames(1);
      chk({f1, f2}, {e1, e2});
      chk({im1, im2}, {i1, i2});
      chk(irq_n, !pn1);
    end
    ctl[7] <= 1'b0;
    for (i = 0; i < 20 && vvalid !== 1'b1; i++) @(posedge i_clk);
    chk({vvalid, vdata}, {1'b1, vup, pn2, pn1});
    ctl[7] <= 1'b1;
    pulse(5);
    chk({f1, irq_n}, {8'h00, 1'b1});
    ctl[3] <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk(irq_n, 1'b0);
    pulse(4);
    chk({f2, im2, irq_n}, {16'h0000, 1'b1});
    ctl[7] <= 1'b0;
    repeat (5) @(posedge i_clk);
    chk(vvalid, 1'b0);
    ctl[7] <= 1'b1;
    frames(1);
    dat[4] = dat[4] ^ 8'h80;
    frames(1);
    chk(irq_n, 1'b0);
    strap <= 1'b0;
    msel <= 1'b1;
    repeat (6) @(posedge i_clk);
    chk({irq_n, f1, im1}, {1'b1, 16'h0000});
    frames(1);
    dat[4] = dat[4] ^ 8'h80;
    frames(1);
    chk({irq_n, f1}, {1'b1, 8'h00});
    for (i = 0; i < 6; i++) begin
      wa = 8'(rnd());
      tdm_host_model_i.access(1'b1, wa[5:0], 8'h00, q, bz);
      chk({q, bz[1]}, {dat[wa[4:0]], 1'b0});
    end
    at_cnt(4'h8);
    at_cnt(4'hF);
    c = ch;
    tdm_host_model_i.access(1'b1, {1'b0, c}, 8'h00, q, bz);
    chk(q, dat[c]);
    chk(bz, 1);
    at_cnt(4'h8);
    at_cnt(4'hF);
    c = nxt(ch);
    wa = 8'(rnd());
    tdm_host_model_i.access(1'b0, {1'b0, c}, wa, q, bz);
    chk(bz, 1);
    at_cnt(4'h8);
    at_cnt(4'hF);
    cw = ch;
    wb = 8'(rnd());
    tdm_host_model_i.access(1'b0, {1'b1, cw}, wb, q, bz);
    chk(bz, 0);
    at_cnt(4'h4);
    tdm_host_model_i.access(1'b1, {1'b1, ch}, 8'h00, q, bz);
    chk({q, bz[1:0]}, {dat[ch], 2'b00});
    frames(2);
    chk({got_a[c], got_b[cw]}, {wa, wb});
    msel <= 1'b0;
    tdm_host_model_i.select(1'b0);
    frames(1);
    m3 <= 1'b1;
    frames(1);
    csel <= 1'b0;
    nch_m1 <= 5'h17;
    frames(2);
    m3 <= 1'b0;
    conclude();
  end
endmodule

// ---- testbench/tdm_host_model.sv ----
// bench model of the host on the static-memory and bus-controller pins
// assumes a registered busy flag that shows within a few clocks of a colliding access
`timescale 1ns/10ps
module tdm_host_model (
  // clock and device answers
  input wire logic i_clk,
  input wire logic i_busy,
  input wire logic [7:0] i_rdata,
  // host pins
  output logic o_cs_n = 1'b1,
  output logic o_oe_n = 1'b1,
  output logic o_rw = 1'b1,
  output logic [5:0] o_addr = 6'h00,
  output logic [7:0] o_wdata = 8'h00
);
  // one memory cycle, held until busy stayed low six edges; bz 0 clean, 1 busy seen, 2 timeout
  task automatic access(input logic r, input logic [5:0] a, input logic [7:0] d,
      output logic [7:0] q, output int bz);
    int quiet;
    int n;
    bz = 0;
    quiet = 0;
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    o_oe_n <= ~r;
    o_rw <= r;
    o_addr <= a;
    o_wdata <= d;
    for (n = 0; n < 300 && quiet < 6; n++) begin
      @(posedge i_clk);
      quiet = i_busy ? 0 : quiet + 1;
      if (i_busy) bz = 1;
    end
    if (quiet < 6) bz = 2;
    q = i_rdata;
    o_cs_n <= 1'b1;
    o_oe_n <= 1'b1;
    o_wdata <= ~d;  // released data must not look like the last value
  endtask
  // bus-controller mode: select stays low through read and write phases
  task automatic select(input logic v);
    @(posedge i_clk);
    o_cs_n <= v;
  endtask
endmodule
